// ==== verilog/serial_audio_rx_volume.sv ====
// Serial audio receiver with DC filter and ramped digital volume
// Operation
// - Sample frame clock and data on bit-clock rise
// - I2S words start one bit after edge
// - MSB-first two's complement, no precision needed
// - Format code 100 selects I2S alignment
// - Left-justified words start on the edge itself
// - Right-justified LSB ends at frame-clock edge
// - Right-justified precision 24/20/18/16 by code
// - TDM frame starts on frame-clock rise
// - Slot count detected from bits per frame
// - I2S TDM slot 0 one bit late
// - Left-justified TDM slot 0 on rise
// - Right-justified TDM LSB-aligned in 32-bit slot
// - Excess DC with filter bypassed latches fault, stops power stage
// - High-pass filter, bypass by bit 7
// - Corner code doubles filter corner per step
// - Analog gain code selects full-scale level
// - Volume code 0x19E plus quarter-dB steps
// - Volume upper bits and LSB in two registers
// - Codes below 0x0E mute the audio
// - Ramp one step per frame or eight
// - Saturate when level exceeds full scale
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
module serial_audio_rx_volume #(
   parameter logic [23:0] DC_LIMIT = 24'h080000,
   parameter logic [7:0] DC_FRAMES = 8'h10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   serial_audio_port_if.device port,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output audio_pkg::sample_t audioOut,
   output logic audioValid,
   output logic powerStageOn,
   output logic [1:0] analogGain,
   output logic [8:0] fullScaleDbv
);
   import audio_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic sample_t rjAlign(input logic [31:0] w,
                                      input logic [1:0] prec);
      case (prec)
         2'h0: rjAlign = w[23:0];
         2'h1: rjAlign = {w[19:0], 4'h0};
         2'h2: rjAlign = {w[17:0], 6'h00};
         default: rjAlign = {w[15:0], 8'h00};
      endcase
   endfunction : rjAlign

   function automatic sample_t sat24(input logic signed [47:0] v);
      if (v > 48'sh7fffff) begin
         sat24 = 24'sh7fffff;
      end else if (v < -48'sh800000) begin
         sat24 = -24'sh800000;
      end else begin
         sat24 = v[23:0];
      end
   endfunction : sat24

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [7:0] formatReg_q, rampReg_q, volReg_q, ctrl3Reg_q, gainReg_q;
   logic dcFault_q, dcFaultSet, tdm_q;
   logic [3:0] slots_q;
   logic [8:0] volNow_q, volTarget;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         formatReg_q <= FORMAT_RST;
         rampReg_q <= RAMP_RST;
         volReg_q <= VOLUME_RST;
         ctrl3Reg_q <= CTRL3_RST;
         gainReg_q <= GAIN_RST;
      end else if (regWr) begin
         case (regAddr)
            REG_FORMAT: formatReg_q <= regWrData;
            REG_RAMP: rampReg_q <= regWrData;
            REG_VOLUME: volReg_q <= regWrData;
            REG_CTRL3: ctrl3Reg_q <= regWrData;
            REG_GAIN: gainReg_q <= regWrData;
            default: ;
         endcase
      end
   end

   assign volTarget = {volReg_q, ctrl3Reg_q[VOL_LSB_BIT]};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            REG_FORMAT: regRdData <= formatReg_q;
            REG_RAMP: regRdData <= rampReg_q;
            REG_VOLUME: regRdData <= volReg_q;
            REG_CTRL3: regRdData <= ctrl3Reg_q;
            REG_GAIN: regRdData <= gainReg_q;
            REG_STATUS: regRdData <= {1'b0, volNow_q != volTarget, tdm_q,
                                      slots_q, dcFault_q};
            REG_VOLNOW: regRdData <= volNow_q[8:1];
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pinMeta_q, pinSync_q;
   logic bclkPrev_q, bitTick, lrNow, sdNow;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pinMeta_q <= 3'h0;
         pinSync_q <= 3'h0;
         bclkPrev_q <= 1'b0;
      end else begin
         pinMeta_q <= {port.bitClk, port.frameClk, port.serialAudioIn};
         pinSync_q <= pinMeta_q;
         bclkPrev_q <= pinSync_q[2];
      end
   end

   assign bitTick = pinSync_q[2] & ~bclkPrev_q;
   assign lrNow = pinSync_q[1];
   assign sdNow = pinSync_q[0];

   // ----------------------------------------------------------------
   // Word framing and capture
   // ----------------------------------------------------------------
   logic [2:0] fmt;
   logic lrPrev_q, isI2s, isRj, lrRise, lrFall, wordStart, capture;
   logic frameTick;
   logic [31:0] shift_q;
   logic [8:0] bitIdx_q, idx, frameCnt_q, frameLen;
   sample_t captured;

   assign fmt = formatReg_q[2:0];

   always_comb begin
      isI2s = fmt == FMT_I2S;
      isRj = fmt <= FMT_RJ16;
      lrRise = lrNow & ~lrPrev_q;
      lrFall = ~lrNow & lrPrev_q;
      wordStart = (tdm_q | !isI2s) ? lrRise : lrFall;
      idx = wordStart ? 9'h000 : bitIdx_q + 9'h001;
      frameLen = frameCnt_q + 9'h001;
      frameTick = bitTick & lrRise;
   end

   always_comb begin
      capture = 1'b0;
      captured = '0;
      if (bitTick) begin
         if (!isRj) begin
            capture = idx == (isI2s ? 9'h018 : 9'h017);
            captured = {shift_q[22:0], sdNow};
         end else if (tdm_q) begin
            capture = idx == 9'h01f;
            captured = rjAlign({shift_q[30:0], sdNow}, fmt[1:0]);
         end else begin
            capture = lrFall;
            captured = rjAlign(shift_q, fmt[1:0]);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lrPrev_q <= 1'b0;
         shift_q <= 32'h0;
         bitIdx_q <= 9'h000;
         frameCnt_q <= 9'h000;
      end else if (bitTick) begin
         lrPrev_q <= lrNow;
         shift_q <= {shift_q[30:0], sdNow};
         bitIdx_q <= idx;
         frameCnt_q <= lrRise ? 9'h000 : frameCnt_q + 9'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tdm_q <= 1'b0;
         slots_q <= 4'h2;
      end else if (frameTick) begin
         case (frameLen)
            RATIO_32, RATIO_48, RATIO_64: begin
               tdm_q <= 1'b0;
               slots_q <= 4'h2;
            end
            RATIO_TDM4: begin
               tdm_q <= 1'b1;
               slots_q <= 4'h4;
            end
            RATIO_TDM8: begin
               tdm_q <= 1'b1;
               slots_q <= 4'h8;
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // DC filter and DC fault
   // ----------------------------------------------------------------
   logic signed [39:0] dcEst_q, xWide;
   logic signed [40:0] dcDiff;
   logic [3:0] hpfShift;
   logic [23:0] dcMag;
   logic [7:0] dcCnt_q;
   logic bypass, dcHigh, hpfValid_q;
   sample_t hpfOut_q;

   always_comb begin
      bypass = formatReg_q[BYPASS_BIT];
      hpfShift = HPF_SHIFT_BASE - {1'b0, ctrl3Reg_q[CORNER_LSB +: 3]};
      xWide = {captured, 16'h0000};
      dcDiff = {xWide[39], xWide} - {dcEst_q[39], dcEst_q};
      dcMag = dcEst_q[39] ? 24'(-dcEst_q[39:16]) : dcEst_q[39:16];
      dcHigh = bypass & (dcMag > DC_LIMIT);
      dcFaultSet = capture & dcHigh & (dcCnt_q == DC_FRAMES - 8'h01);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dcEst_q <= 40'sh0;
         hpfOut_q <= '0;
         hpfValid_q <= 1'b0;
      end else begin
         hpfValid_q <= capture;
         if (capture) begin
            dcEst_q <= dcEst_q + 40'(dcDiff >>> hpfShift);
            hpfOut_q <= bypass ? captured : sat24(48'(dcDiff >>> 16));
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dcCnt_q <= 8'h00;
      end else if (capture) begin
         if (!dcHigh) begin
            dcCnt_q <= 8'h00;
         end else if (dcCnt_q != DC_FRAMES - 8'h01) begin
            dcCnt_q <= dcCnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dcFault_q <= 1'b0;
      end else if (dcFaultSet) begin
         dcFault_q <= 1'b1;
      end else if (regWr && regAddr == REG_STATUS && regWrData[FAULT_BIT]) begin
         dcFault_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Volume ramp
   // ----------------------------------------------------------------
   logic [2:0] rampDiv_q;
   logic stepNow;

   assign stepNow = frameTick & (!rampReg_q[RAMP_BIT] ||
      rampDiv_q == 3'(SLOW_RAMP_FRAMES - 1));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rampDiv_q <= 3'h0;
      end else if (frameTick) begin
         rampDiv_q <= rampDiv_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         volNow_q <= {VOLUME_RST, CTRL3_RST[VOL_LSB_BIT]};
      end else if (stepNow && volNow_q != volTarget) begin
         volNow_q <= (volNow_q < volTarget) ? volNow_q + 9'h001
                                            : volNow_q - 9'h001;
      end
   end

   // ----------------------------------------------------------------
   // Gain stage and outputs
   // ----------------------------------------------------------------
   logic [9:0] volBiased, expo, mantIdx;
   logic [5:0] rShift;
   logic signed [47:0] prod, scaled;

   always_comb begin
      volBiased = {1'b0, volNow_q} + VOL_EXP_BIAS;
      expo = volBiased / STEPS_PER_OCTAVE;
      mantIdx = volBiased % STEPS_PER_OCTAVE;
      rShift = GAIN_SHIFT_MAX - expo[5:0];
      prod = hpfOut_q * $signed({1'b0, GAIN_MANT[mantIdx[4:0]]});
      scaled = prod >>> rShift;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         audioOut <= '0;
         audioValid <= 1'b0;
         powerStageOn <= 1'b0;
         analogGain <= 2'h0;
         fullScaleDbv <= 9'h000;
      end else begin
         audioValid <= hpfValid_q;
         if (hpfValid_q) begin
            audioOut <= (volNow_q < VOL_MUTE_BELOW) ? '0
                                                    : sat24(scaled);
         end
         powerStageOn <= !dcFault_q;
         analogGain <= gainReg_q[1:0];
         fullScaleDbv <= FS_DBV_TENTHS[gainReg_q[1:0]];
      end
   end
endmodule : serial_audio_rx_volume

// ==== verilog/audio_pkg.sv ====
// Shared constants and types for the serial audio receiver and its host
package audio_pkg;
   typedef logic signed [23:0] sample_t;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_FORMAT = 8'h02;
   localparam logic [7:0] REG_RAMP = 8'h03;
   localparam logic [7:0] REG_VOLUME = 8'h04;
   localparam logic [7:0] REG_CTRL3 = 8'h13;
   localparam logic [7:0] REG_GAIN = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h21;
   localparam logic [7:0] REG_VOLNOW = 8'h22;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int BYPASS_BIT = 7;
   localparam int RAMP_BIT = 6;
   localparam int CORNER_LSB = 5;
   localparam int VOL_LSB_BIT = 0;
   localparam int FAULT_BIT = 0;
   localparam logic [7:0] FORMAT_RST = 8'h04;
   localparam logic [7:0] RAMP_RST = 8'h00;
   localparam logic [7:0] VOLUME_RST = 8'hcf;
   localparam logic [7:0] CTRL3_RST = 8'h00;
   localparam logic [7:0] GAIN_RST = 8'h00;
   // ----------------------------------------------------------------
   // Format codes
   // ----------------------------------------------------------------
   localparam logic [2:0] FMT_RJ24 = 3'h0;
   localparam logic [2:0] FMT_RJ20 = 3'h1;
   localparam logic [2:0] FMT_RJ18 = 3'h2;
   localparam logic [2:0] FMT_RJ16 = 3'h3;
   localparam logic [2:0] FMT_I2S = 3'h4;
   localparam logic [2:0] FMT_LJ = 3'h5;
   // ----------------------------------------------------------------
   // Volume, gain and filter constants
   // ----------------------------------------------------------------
   localparam logic [8:0] VOL_0DB = 9'h19e;
   localparam logic [8:0] VOL_MUTE_BELOW = 9'h00e;
   localparam logic [9:0] VOL_EXP_BIAS = 10'h012;
   localparam logic [9:0] STEPS_PER_OCTAVE = 10'h018;
   localparam logic [5:0] GAIN_SHIFT_MAX = 6'h21;
   localparam int SLOW_RAMP_FRAMES = 8;
   localparam logic [3:0] HPF_SHIFT_BASE = 4'hb;
   localparam logic [8:0] FS_DBV_TENTHS [4] = '{9'h0c0, 9'h0cf, 9'h0eb,
      9'h107};
   localparam logic [15:0] GAIN_MANT [24] = '{
      16'h8000, 16'h83c0, 16'h879c, 16'h8b96, 16'h8fad, 16'h93e3,
      16'h9838, 16'h9cae, 16'ha145, 16'ha5ff, 16'haadc, 16'hafde,
      16'hb505, 16'hba53, 16'hbfc9, 16'hc567, 16'hcb30, 16'hd124,
      16'hd745, 16'hdd94, 16'he412, 16'heac1, 16'hf1a2, 16'hf8b6};
   // ----------------------------------------------------------------
   // Frame geometry and link timing
   // ----------------------------------------------------------------
   localparam logic [8:0] RATIO_32 = 9'h020;
   localparam logic [8:0] RATIO_48 = 9'h030;
   localparam logic [8:0] RATIO_64 = 9'h040;
   localparam logic [8:0] RATIO_TDM4 = 9'h080;
   localparam logic [8:0] RATIO_TDM8 = 9'h100;
   localparam logic [7:0] LAST_BIT_STEREO = 8'h3f;
   localparam logic [7:0] LAST_BIT_TDM4 = 8'h7f;
   localparam logic [7:0] LAST_BIT_TDM8 = 8'hff;
   localparam int CORE_PERIOD_NS = 25;
   localparam int LINK_PERIOD_NS = 200;
   localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
endpackage : audio_pkg

// ==== verilog/serial_audio_port_if.sv ====
// Serial audio link between host and receiver
`timescale 1ns/100ps
interface serial_audio_port_if;
   logic bitClk;
   logic frameClk;
   logic serialAudioIn;
   modport host (output bitClk, output frameClk, output serialAudioIn);
   modport device (input bitClk, input frameClk, input serialAudioIn);
endinterface : serial_audio_port_if

// ==== verilog/serial_audio_host.sv ====
// Host end that drives the serial audio link
`timescale 1ns/100ps
module serial_audio_host (
   input wire logic core_clk,
   input wire logic rst_n,
   serial_audio_port_if.host port,
   input wire logic [2:0] format,
   input wire logic tdmMode,
   input wire logic eightSlots,
   input audio_pkg::sample_t leftSample,
   input audio_pkg::sample_t rightSample,
   output logic sampleTaken
);
   import audio_pkg::*;

   // ----------------------------------------------------------------
   // Bit clock divider
   // ----------------------------------------------------------------
   logic [3:0] div_q;
   logic bclk_q, halfTick, fallNow;

   assign halfTick = div_q == 4'(LINK_HALF_CYCLES - 1);
   assign fallNow = halfTick & bclk_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_q <= 4'h0;
         bclk_q <= 1'b0;
      end else begin
         div_q <= halfTick ? 4'h0 : div_q + 4'h1;
         if (halfTick) begin
            bclk_q <= ~bclk_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame position and serial bit
   // ----------------------------------------------------------------
   logic [7:0] pos_q, posN, lastBit, dp;
   logic [5:0] nBits, bi;
   logic [4:0] k;
   logic [2:0] chan;
   logic lrN, sdN, lr_q, sd_q;
   sample_t left_q, right_q, lN, rN, word;

   always_comb begin
      lastBit = !tdmMode ? LAST_BIT_STEREO
                         : (eightSlots ? LAST_BIT_TDM8 : LAST_BIT_TDM4);
      posN = (pos_q >= lastBit) ? 8'h00 : pos_q + 8'h01;
      lN = (posN == 8'h00) ? leftSample : left_q;
      rN = (posN == 8'h00) ? rightSample : right_q;
      if (format == FMT_I2S) begin
         dp = (posN == 8'h00) ? lastBit : posN - 8'h01;
      end else begin
         dp = posN;
      end
      chan = dp[7:5];
      k = dp[4:0];
      word = (chan == 3'h0) ? lN : ((chan == 3'h1) ? rN : '0);
      case (format[1:0])
         2'h0: nBits = 6'h18;
         2'h1: nBits = 6'h14;
         2'h2: nBits = 6'h12;
         default: nBits = 6'h10;
      endcase
      bi = 6'h1f - {1'b0, k};
      if (!format[2]) begin
         sdN = ({1'b0, k} >= 6'h20 - nBits) ? word[bi[4:0]] : 1'b0;
      end else begin
         sdN = (k < 5'h18) ? word[5'h17 - k] : 1'b0;
      end
      if (tdmMode) begin
         lrN = posN < 8'h20;
      end else begin
         lrN = (format == FMT_I2S) ? posN[5] : ~posN[5];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pos_q <= 8'hff;
         left_q <= '0;
         right_q <= '0;
         lr_q <= 1'b0;
         sd_q <= 1'b0;
         sampleTaken <= 1'b0;
      end else begin
         sampleTaken <= fallNow && posN == 8'h00;
         if (fallNow) begin
            pos_q <= posN;
            left_q <= lN;
            right_q <= rN;
            lr_q <= lrN;
            sd_q <= sdN;
         end
      end
   end

   assign port.bitClk = bclk_q;
   assign port.frameClk = lr_q;
   assign port.serialAudioIn = sd_q;
endmodule : serial_audio_host

// ==== tb/audio_link_chk.sv ====
// Protocol checker for the serial audio link
`timescale 1ns/100ps
module audio_link_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic bitClk,
   input wire logic frameClk,
   input wire logic serialAudioIn
);
   logic [11:0] frameLen_q;
   logic [11:0] highLen_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Frame counters
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         frameLen_q <= 12'h000;
      else if ($rose(frameClk))
         frameLen_q <= 12'h001;
      else if (frameLen_q != 12'h000)
         frameLen_q <= frameLen_q + 12'h001;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         highLen_q <= 12'h000;
      else if ($rose(frameClk))
         highLen_q <= 12'h001;
      else if (frameClk)
         highLen_q <= highLen_q + 12'h001;
   end
   // ----------------------------------------------------------------
   // Link assertions
   // ----------------------------------------------------------------
   frame_edge_a: assert property (
      $changed(frameClk) |-> $fell(bitClk))
      else $error("frame clock moved off the bit clock fall");
   data_edge_a: assert property (
      $changed(serialAudioIn) |-> $fell(bitClk))
      else $error("data moved off the bit clock fall");
   bit_high_a: assert property (
      $rose(bitClk) |-> bitClk [*4] ##1 !bitClk)
      else $error("bit clock high phase wrong");
   bit_low_a: assert property (
      $fell(bitClk) |-> !bitClk [*4] ##1 bitClk)
      else $error("bit clock low phase wrong");
   frame_high_a: assert property (
      $rose(frameClk) |-> frameClk [*8])
      else $error("frame clock high under one bit");
   frame_low_a: assert property (
      $fell(frameClk) |-> !frameClk [*8])
      else $error("frame clock low under one bit");
   frame_len_a: assert property (
      $rose(frameClk) && frameLen_q != 12'h000
         |-> frameLen_q inside {12'h200, 12'h400, 12'h800})
      else $error("frame length not a valid ratio");
   half_frame_a: assert property (
      $fell(frameClk) |-> highLen_q == 12'h100)
      else $error("frame clock high span not 32 bits");
endmodule : audio_link_chk

// ==== tb/tb.sv ====
// Testbench joining host and receiver over the serial audio link
`timescale 1ns/100ps
module tb;
   import audio_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   sample_t audioOut;
   logic audioValid, powerStageOn, sampleTaken;
   logic [1:0] analogGain;
   logic [8:0] fullScaleDbv;
   logic [2:0] format = FMT_I2S;
   logic tdmMode = 1'b0;
   logic eightSlots = 1'b0;
   sample_t leftSample = 24'h5a3c96;
   sample_t rightSample = 24'h123456;
   int error_cnt = 0;
   int compares = 0;
   logic [7:0] d;
   serial_audio_port_if link ();
   serial_audio_host serial_audio_host_inst (.core_clk(core_clk),
      .rst_n(rst_n), .port(link.host), .format(format),
      .tdmMode(tdmMode), .eightSlots(eightSlots),
      .leftSample(leftSample), .rightSample(rightSample),
      .sampleTaken(sampleTaken));
   serial_audio_rx_volume #(.DC_FRAMES(8'h02)) serial_audio_rx_volume_inst (
      .core_clk(core_clk), .rst_n(rst_n), .port(link.device),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .audioOut(audioOut),
      .audioValid(audioValid), .powerStageOn(powerStageOn),
      .analogGain(analogGain), .fullScaleDbv(fullScaleDbv));
   audio_link_chk audio_link_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
      .bitClk(link.bitClk), .frameClk(link.frameClk),
      .serialAudioIn(link.serialAudioIn));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [23:0] got, input logic [23:0] exp,
         input string m);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   task automatic do_reset;
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic frames(input int n);
      repeat (n) begin
         @(negedge core_clk);
         while (sampleTaken !== 1'b1) @(negedge core_clk);
      end
   endtask : frames
   task automatic wait_valid;
      @(negedge core_clk);
      while (audioValid !== 1'b1) @(negedge core_clk);
   endtask : wait_valid
   function automatic sample_t expw(input logic [2:0] f, input sample_t w);
      case (f)
         3'h1: return {w[19:0], 4'h0};
         3'h2: return {w[17:0], 6'h00};
         3'h3: return {w[15:0], 8'h00};
         default: return w;
      endcase
   endfunction : expw
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      logic [7:0] ra [6] = '{8'h02, 8'h03, 8'h04, 8'h13, 8'h20, 8'h55};
      logic [7:0] rv [6] = '{8'h04, 8'h00, 8'hcf, 8'h00, 8'h00, 8'h00};
      do_reset();
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk(24'(d), 24'(rv[i]), "register reset value");
      end
      chk(24'(powerStageOn), 24'h1, "power stage off");
   endtask : t_regs
   task automatic t_gain;
      logic [8:0] dbv [4] = '{9'd192, 9'd207, 9'd235, 9'd263};
      for (int g = 0; g < 4; g++) begin
         wr(8'h20, 8'(g));
         repeat (3) @(posedge core_clk);
         chk(24'(analogGain), 24'(g), "gain code");
         chk(24'(fullScaleDbv), 24'(dbv[g]), "full scale level");
      end
   endtask : t_gain
   task automatic t_fmt(input int m, input logic [2:0] f);
      @(posedge core_clk);
      format <= f;
      tdmMode <= (m != 0);
      eightSlots <= (m == 2);
      do_reset();
      wr(8'h02, {5'h10, f});
      frames(4);
      wait_valid();
      chk(audioOut, expw(f, leftSample), "word alignment");
      rd(8'h21);
      chk(24'(d[5:1]), 24'((m != 0) * 16 + (2 << m)), "slot count");
   endtask : t_fmt
   task automatic t_vol;
      @(posedge core_clk);
      format <= FMT_LJ;
      tdmMode <= 1'b0;
      do_reset();
      wr(8'h02, 8'h85);
      wr(8'h04, 8'hce);
      frames(1);
      rd(8'h21);
      chk(24'(d[6]), 24'h1, "ramp not running");
      frames(4);
      rd(8'h22);
      chk(24'(d), 24'hce, "ramp end value");
      wr(8'h03, 8'h40);
      wr(8'h04, 8'hcf);
      frames(5);
      rd(8'h22);
      chk(24'(d), 24'hce, "slow ramp too fast");
      frames(14);
      rd(8'h22);
      chk(24'(d), 24'hcf, "slow ramp end value");
      wr(8'h03, 8'h00);
      wr(8'h04, 8'hd6);
      frames(16);
      rd(8'h22);
      chk(24'(d), 24'hd6, "gain ramp end value");
      wait_valid();
      chk(audioOut, 24'h7fffff, "no clipping above full scale");
   endtask : t_vol
   task automatic t_dc;
      int n;
      @(posedge core_clk);
      format <= FMT_LJ;
      leftSample <= 24'h400000;
      do_reset();
      wr(8'h02, 8'h05);
      wr(8'h13, 8'he0);
      frames(30);
      wait_valid();
      chk(24'(audioOut < 24'sh100000), 24'h1, "dc not removed");
      chk(24'(powerStageOn), 24'h1, "fault with filter on");
      wr(8'h02, 8'h85);
      frames(6);
      wait_valid();
      chk(audioOut, 24'h400000, "bypass altered data");
      n = 0;
      while (powerStageOn !== 1'b0 && n < 20) begin
         frames(1);
         n++;
      end
      @(posedge core_clk);
      leftSample <= 24'h000000;
      frames(3);
      chk(24'(powerStageOn), 24'h0, "dc fault not latched");
      rd(8'h21);
      chk(24'(d[0]), 24'h1, "fault flag clear");
   endtask : t_dc
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      t_regs();
      t_gain();
      for (int m = 0; m < 3; m++) begin
         for (int f = 0; f < 6; f++) begin
            if (m == 0 || (m == 1 && f inside {0, 4, 5}) || (m == 2 && f == 3))
               t_fmt(m, 3'(f));
         end
      end
      t_vol();
      t_dc();
      report_and_stop();
   end
   initial begin
      repeat (95000) @(posedge core_clk);
      error_cnt++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : tb
